// ### core/pks_panel.sv
// front panel keypad, mode/axis/digit control and status display
// assumes drive status inputs synchronous to SYS_CLK, one AHB-Lite master
//
// Contract
// R1 - short function press cycles the four modes
// R2 - long function press toggles addressed axis
// R3 - long press means held over one second
// R4 - up increments value, or jogs forward
// R5 - down decrements value, or jogs reverse
// R6 - shift moves flashing digit one left
// R7 - set shows parameter, enters editing state
// R8 - status mode set or reset input clears
// R9 - run segment lit while servo on
// R10 - axis A speed coincide below threshold
// R11 - position mode: deviation below done threshold
// R12 - torque segment lit above rated plus ten
// R13 - axis B rotation detect below threshold
// R14 - limit: fwd on, rev off, both flash
// R15 - mains segment follows main power present
// R16 - code shows all off or servo on
// R17 - code shows overtravel of prohibited axis
// R18 - alarm code with number has priority
// R19 - debounced keys, one event at release
//
// Local design decisions: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module pks_panel #(
  parameter int DEB_CYC   = pks_pkg::DEBOUNCE_CYC,
  parameter int LONG_CYC  = pks_pkg::LONG_PRESS_CYC,
  parameter int BLINK_CYC = pks_pkg::BLINK_CYC
) (
  // clock and reset
  input  wire logic               SYS_CLK,
  input  wire logic               RST,

  // ahb-lite slave
  input  wire logic               HSEL,
  input  wire logic [31:0]        HADDR,
  input  wire logic [1:0]         HTRANS,
  input  wire logic               HWRITE,
  input  wire logic [2:0]         HSIZE,
  input  wire logic [31:0]        HWDATA,
  input  wire logic               HREADY,
  output logic                    HREADYOUT,
  output logic                    HRESP,
  output logic [31:0]             HRDATA,

  // keys, active high while pressed
  input  wire logic [4:0]         KEYS,

  // drive status
  input  wire pks_pkg::pks_axis_t AXIS_A,
  input  wire pks_pkg::pks_axis_t AXIS_B,
  input  wire logic               POS_MODE_A,
  input  wire logic [15:0]        POS_DEV_A,
  input  wire logic               MAINS_READY,
  input  wire logic               ALARM_RESET_IN,

  // operator outputs
  output pks_pkg::pks_mode_t      MODE,
  output logic                    AXIS_B_SEL,
  output logic [2:0]              DIGIT_SEL,
  output logic                    DP_FLASH,
  output logic                    EDIT_ACTIVE,
  output logic [19:0]             EDIT_VALUE,
  output logic                    JOG_FWD,
  output logic                    JOG_REV,
  output logic                    ALARM_CLEAR,

  // display
  output logic [8:0]              INDICATORS,
  output pks_pkg::pks_code_t      STATUS_CODE,
  output logic [7:0]              ALARM_NUM,

  // interrupt
  output logic                    IRQ
);
  typedef struct packed {
    pks_pkg::pks_mode_t mode;
    logic               axis_b;
    logic [2:0]         digit;
    logic               edit_active;
    logic [19:0]        edit_val;

    logic               jog_fwd;
    logic               jog_rev;
    logic               alarm_clear;

    logic [8:0]         ind;
    pks_pkg::pks_code_t code;
    logic [7:0]         alarm_num;

    logic [31:0]        blink_cnt;
    logic               blink;
    logic               alm_in_q;

    logic [15:0]        spd_thr;
    logic [15:0]        pos_thr;
    logic [15:0]        rot_thr;
    logic               jog_en;
    logic [3:0]         irq_stat;
    logic [3:0]         irq_mask;

    logic               wr_pend;
    logic [7:0]         wr_addr;
    logic [31:0]        rdata;
  } pks_panel_st_t;

  pks_panel_st_t s;
  pks_panel_st_t next_s;

  logic [4:0] key_short;
  logic [4:0] key_long;
  logic [4:0] key_level;

  // one debouncer per key
  for (genvar k = 0; k < pks_pkg::NUM_KEYS; k++) begin : g_key
    pks_key #(
      .DEB_CYC  (DEB_CYC),
      .LONG_CYC (LONG_CYC)
    ) u_key (
      .SYS_CLK (SYS_CLK),
      .RST     (RST),
      .KEY_RAW (KEYS[k]),
      .SHORT_P (key_short[k]),
      .LONG_P  (key_long[k]),
      .LEVEL   (key_level[k])
    );
  end

  // step the selected bcd digit up or down with wrap inside the digit
  function automatic logic [19:0] bcd_step(input logic [19:0] v,
                                           input logic [2:0] d,
                                           input logic up);
    logic [19:0] r;
    logic [3:0]  nib;
    r = v;
    for (int i = 0; i < pks_pkg::NUM_DIGITS; i++) begin
      if (d == 3'(i)) begin
        nib = v[4*i +: 4];
        if (up) nib = (nib >= 4'h9) ? 4'h0 : nib + 4'h1;
        else nib = (nib == 4'h0) ? 4'h9 : nib - 4'h1;
        r[4*i +: 4] = nib;
      end
    end
    return r;
  endfunction : bcd_step

  // actual torque beyond rated by ten percent
  function automatic logic trq_over(input pks_pkg::pks_axis_t ax);
    logic [19:0] lhs;
    logic [19:0] rhs;
    lhs = 20'(ax.torque) * 20'(pks_pkg::TRQ_DEN);
    rhs = 20'(ax.rated) * 20'(pks_pkg::TRQ_NUM);
    return lhs > rhs;
  endfunction : trq_over

  // limit segment: forward lit, reverse dark, both flashing
  function automatic logic lim_seg(input pks_pkg::pks_axis_t ax,
                                   input logic blink);
    if (ax.fwd_proh && ax.rev_proh) return blink;
    return ax.fwd_proh;
  endfunction : lim_seg

  logic       acc;
  logic       edit_key;
  logic       jog_ctx;
  logic [3:0] ev;
  logic       set_p;
  logic [31:0] status_word;

  // keys pressed once, regardless of hold length, except function
  assign set_p   = key_short[pks_pkg::KEY_SET] | key_long[pks_pkg::KEY_SET];
  assign jog_ctx = (s.mode == pks_pkg::MODE_AUX) && s.jog_en;
  assign edit_key = s.edit_active && !jog_ctx;
  assign acc = HSEL && HTRANS[1] && HREADY;
  assign status_word = {3'h0, s.alarm_num, s.code, s.ind, s.jog_rev,
                        s.jog_fwd, s.edit_active, s.digit, s.axis_b, s.mode};

  // next state: keys, display, bus and interrupts
  always_comb begin
    next_s = s;
    next_s.alarm_clear = 1'b0;
    ev = '0;

    // flash timebase for limit segments and digit point
    if (s.blink_cnt >= 32'(BLINK_CYC - 1)) begin
      next_s.blink_cnt = '0;
      next_s.blink = !s.blink;
    end else begin
      next_s.blink_cnt = s.blink_cnt + 32'd1;
    end

    // function key
    if (key_short[pks_pkg::KEY_FUNC]) begin
      unique case (s.mode)
        pks_pkg::MODE_STATUS: next_s.mode = pks_pkg::MODE_AUX; // R1
        pks_pkg::MODE_AUX:    next_s.mode = pks_pkg::MODE_PARAM; // R1
        pks_pkg::MODE_PARAM:  next_s.mode = pks_pkg::MODE_MON; // R1
        pks_pkg::MODE_MON:    next_s.mode = pks_pkg::MODE_STATUS; // R1
      endcase
      next_s.edit_active = 1'b0;
      ev[pks_pkg::IRQ_MODE_STEP] = 1'b1;
    end
    if (key_long[pks_pkg::KEY_FUNC]) begin
      next_s.axis_b = !s.axis_b; // R2
      ev[pks_pkg::IRQ_AXIS_TOG] = 1'b1;
    end

    // jog outputs follow the held key, so motion stops on release
    next_s.jog_fwd = jog_ctx && key_level[pks_pkg::KEY_UP]; // R4
    next_s.jog_rev = jog_ctx && key_level[pks_pkg::KEY_DOWN]
                     && !key_level[pks_pkg::KEY_UP]; // R5

    // value editing on the selected digit
    if (edit_key && (key_short[pks_pkg::KEY_UP] | key_long[pks_pkg::KEY_UP]))
      next_s.edit_val = bcd_step(s.edit_val, s.digit, 1'b1); // R4
    else if (edit_key && (key_short[pks_pkg::KEY_DOWN] | key_long[pks_pkg::KEY_DOWN]))
      next_s.edit_val = bcd_step(s.edit_val, s.digit, 1'b0); // R5
    if (key_short[pks_pkg::KEY_SHIFT] | key_long[pks_pkg::KEY_SHIFT]) begin
      next_s.digit = (s.digit >= 3'(pks_pkg::NUM_DIGITS - 1)) ? 3'h0
                     : s.digit + 3'h1; // R6
    end

    // set key: clear alarm in status mode, else enter/leave editing
    if (set_p) begin
      ev[pks_pkg::IRQ_SET_KEY] = 1'b1;
      if (s.mode == pks_pkg::MODE_STATUS) begin
        next_s.alarm_clear = 1'b1; // R8
      end else begin
        next_s.edit_active = !s.edit_active; // R7
        next_s.digit = 3'h0;
      end
    end

    // external reset input acts on its rising edge only
    next_s.alm_in_q = ALARM_RESET_IN;
    if (ALARM_RESET_IN && !s.alm_in_q) next_s.alarm_clear = 1'b1; // R8
    if (next_s.alarm_clear) ev[pks_pkg::IRQ_ALM_CLR] = 1'b1;

    // indicator segments
    next_s.ind[pks_pkg::IND_A_RUN] = AXIS_A.servo_on; // R9
    next_s.ind[pks_pkg::IND_B_RUN] = AXIS_B.servo_on; // R9
    if (POS_MODE_A)
      next_s.ind[pks_pkg::IND_A_CMP] = POS_DEV_A < s.pos_thr; // R11
    else
      next_s.ind[pks_pkg::IND_A_CMP] = AXIS_A.spd_err < s.spd_thr; // R10
    next_s.ind[pks_pkg::IND_A_TRQ] = trq_over(AXIS_A); // R12
    next_s.ind[pks_pkg::IND_B_TRQ] = trq_over(AXIS_B); // R12
    next_s.ind[pks_pkg::IND_B_ROT] = AXIS_B.spd_err < s.rot_thr; // R13
    next_s.ind[pks_pkg::IND_A_LIM] = lim_seg(AXIS_A, s.blink); // R14
    next_s.ind[pks_pkg::IND_B_LIM] = lim_seg(AXIS_B, s.blink); // R14
    next_s.ind[pks_pkg::IND_MAINS] = MAINS_READY; // R15

    // status code, alarm first, then overtravel, then servo state
    next_s.alarm_num = 8'h00;
    if (AXIS_A.alarm) begin
      next_s.code = pks_pkg::CODE_A_ALM; // R18
      next_s.alarm_num = AXIS_A.alarm_num; // R18
    end else if (AXIS_B.alarm) begin
      next_s.code = pks_pkg::CODE_B_ALM; // R18
      next_s.alarm_num = AXIS_B.alarm_num; // R18
    end else if (AXIS_A.fwd_proh || AXIS_A.rev_proh) begin
      next_s.code = pks_pkg::CODE_A_OT; // R17
    end else if (AXIS_B.fwd_proh || AXIS_B.rev_proh) begin
      next_s.code = pks_pkg::CODE_B_OT; // R17
    end else if (AXIS_A.servo_on) begin
      next_s.code = pks_pkg::CODE_A_ON; // R16
    end else if (AXIS_B.servo_on) begin
      next_s.code = pks_pkg::CODE_B_ON; // R16
    end else begin
      next_s.code = pks_pkg::CODE_ALL_OFF; // R16
    end

    // bus data phase write of the captured address
    next_s.wr_pend = acc && HWRITE;
    if (acc) next_s.wr_addr = HADDR[7:0];
    if (s.wr_pend) begin
      unique case (s.wr_addr)
        pks_pkg::OFS_CTRL:     next_s.jog_en = HWDATA[pks_pkg::CTRL_JOG_EN];
        pks_pkg::OFS_SPD_THR:  next_s.spd_thr = HWDATA[15:0];
        pks_pkg::OFS_POS_THR:  next_s.pos_thr = HWDATA[15:0];
        pks_pkg::OFS_ROT_THR:  next_s.rot_thr = HWDATA[15:0];
        pks_pkg::OFS_EDIT:     next_s.edit_val = HWDATA[19:0];
        pks_pkg::OFS_IRQ_MASK: next_s.irq_mask = HWDATA[3:0];
        default: ;
      endcase
    end

    // read data is fetched in the address phase; interrupt status clears on read
    if (acc && !HWRITE) begin
      unique case (HADDR[7:0])
        pks_pkg::OFS_CTRL:     next_s.rdata = {31'h0, s.jog_en};
        pks_pkg::OFS_SPD_THR:  next_s.rdata = {16'h0, s.spd_thr};
        pks_pkg::OFS_POS_THR:  next_s.rdata = {16'h0, s.pos_thr};
        pks_pkg::OFS_ROT_THR:  next_s.rdata = {16'h0, s.rot_thr};
        pks_pkg::OFS_STATUS:   next_s.rdata = status_word;
        pks_pkg::OFS_EDIT:     next_s.rdata = {12'h0, s.edit_val};
        pks_pkg::OFS_IRQ_STAT: next_s.rdata = {28'h0, s.irq_stat};
        pks_pkg::OFS_IRQ_MASK: next_s.rdata = {28'h0, s.irq_mask};
        default:               next_s.rdata = 32'h0;
      endcase
      if (HADDR[7:0] == pks_pkg::OFS_IRQ_STAT) next_s.irq_stat = 4'h0;
    end

    // a new event in the clearing cycle survives the read
    next_s.irq_stat = next_s.irq_stat | ev;
  end

  // all panel state in one register
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      s <= '0;
      s.mode <= pks_pkg::MODE_STATUS;
      s.code <= pks_pkg::CODE_ALL_OFF;
      s.spd_thr <= pks_pkg::RST_SPD_THR; // R10
      s.pos_thr <= pks_pkg::RST_POS_THR; // R11
      s.rot_thr <= pks_pkg::RST_ROT_THR; // R13
      s.irq_mask <= pks_pkg::RST_MASK;
    end else begin
      s <= next_s;
    end
  end

  // bus answers in zero wait states, always okay
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign HRDATA    = s.rdata;

  // operator and display outputs
  assign MODE        = s.mode;
  assign AXIS_B_SEL  = s.axis_b;
  assign DIGIT_SEL   = s.digit;
  assign DP_FLASH    = s.edit_active && s.blink; // R6
  assign EDIT_ACTIVE = s.edit_active;
  assign EDIT_VALUE  = s.edit_val;
  assign JOG_FWD     = s.jog_fwd;
  assign JOG_REV     = s.jog_rev;
  assign ALARM_CLEAR = s.alarm_clear;
  assign INDICATORS  = s.ind;
  assign STATUS_CODE = s.code;
  assign ALARM_NUM   = s.alarm_num;
  assign IRQ         = |(s.irq_stat & s.irq_mask);
endmodule : pks_panel

// ### shared/pks_pkg.sv
// panel keypad and status display: shared constants and types
// assumes a single 100 MHz system clock and an AHB-Lite register port
package pks_pkg;
  // clock and timing
  localparam int CLK_KHZ        = 100000;
  localparam int DEBOUNCE_MS    = 10;
  localparam int LONG_PRESS_MS  = 1000;
  localparam int BLINK_MS       = 250;
  localparam int DEBOUNCE_CYC   = DEBOUNCE_MS * CLK_KHZ;
  localparam int LONG_PRESS_CYC = LONG_PRESS_MS * CLK_KHZ;
  localparam int BLINK_CYC      = BLINK_MS * CLK_KHZ;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_SPD_THR  = 8'h04;
  localparam logic [7:0] OFS_POS_THR  = 8'h08;
  localparam logic [7:0] OFS_ROT_THR  = 8'h0c;
  localparam logic [7:0] OFS_STATUS   = 8'h10;
  localparam logic [7:0] OFS_EDIT     = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;

  // reset values
  localparam logic [15:0] RST_SPD_THR = 16'h000a;
  localparam logic [15:0] RST_POS_THR = 16'h000a;
  localparam logic [15:0] RST_ROT_THR = 16'h0014;
  localparam logic [3:0]  RST_MASK    = 4'h0;

  // field positions
  localparam int CTRL_JOG_EN   = 0;
  localparam int IRQ_MODE_STEP = 0;
  localparam int IRQ_AXIS_TOG  = 1;
  localparam int IRQ_ALM_CLR   = 2;
  localparam int IRQ_SET_KEY   = 3;
  localparam int NUM_DIGITS    = 5;
  localparam int NUM_KEYS      = 5;
  localparam int KEY_FUNC      = 0;
  localparam int KEY_UP        = 1;
  localparam int KEY_DOWN      = 2;
  localparam int KEY_SHIFT     = 3;
  localparam int KEY_SET       = 4;
  // indicator segment positions
  localparam int IND_A_RUN = 0;
  localparam int IND_A_CMP = 1;
  localparam int IND_A_TRQ = 2;
  localparam int IND_A_LIM = 3;
  localparam int IND_B_RUN = 4;
  localparam int IND_B_TRQ = 5;
  localparam int IND_B_ROT = 6;
  localparam int IND_B_LIM = 7;
  localparam int IND_MAINS = 8;
  // torque limit is rated plus ten percent: act*10 > rated*11
  localparam int TRQ_NUM = 11;
  localparam int TRQ_DEN = 10;

  typedef enum logic [1:0] {
    MODE_STATUS = 2'b00,
    MODE_AUX    = 2'b01,
    MODE_PARAM  = 2'b10,
    MODE_MON    = 2'b11
  } pks_mode_t;

  typedef enum logic [2:0] {
    CODE_ALL_OFF = 3'b000,
    CODE_A_ON    = 3'b001,
    CODE_B_ON    = 3'b010,
    CODE_A_OT    = 3'b011,
    CODE_B_OT    = 3'b100,
    CODE_A_ALM   = 3'b101,
    CODE_B_ALM   = 3'b110
  } pks_code_t;

  // drive status of one axis
  typedef struct packed {
    logic        servo_on;
    logic        alarm;
    logic [7:0]  alarm_num;
    logic        fwd_proh;
    logic        rev_proh;
    logic [15:0] torque;
    logic [15:0] rated;
    logic [15:0] spd_err;
  } pks_axis_t;
endpackage : pks_pkg

// ### core/pks_key.sv
// one debounced key with short/long press detection on release
// assumes the raw key level is already synchronous to SYS_CLK
`timescale 1ns/1ps
module pks_key #(
  parameter int DEB_CYC  = pks_pkg::DEBOUNCE_CYC,
  parameter int LONG_CYC = pks_pkg::LONG_PRESS_CYC
) (
  // clock and reset
  input  wire logic SYS_CLK,
  input  wire logic RST,
  // key
  input  wire logic KEY_RAW,
  output logic      SHORT_P,
  output logic      LONG_P,
  output logic      LEVEL
);
  typedef struct packed {
    logic        level;
    logic [31:0] deb_cnt;
    logic [31:0] hold_cnt;
    logic        long_seen;
    logic        short_p;
    logic        long_p;
  } pks_key_st_t;

  pks_key_st_t s;
  pks_key_st_t next_s;

  // debounce, hold timing, one event per press at release
  always_comb begin
    next_s = s;
    next_s.short_p = 1'b0;
    next_s.long_p = 1'b0;
    if (KEY_RAW != s.level) begin
      if (s.deb_cnt >= 32'(DEB_CYC - 1)) begin
        next_s.level = KEY_RAW; // R19
        next_s.deb_cnt = '0;
        if (!KEY_RAW) begin
          next_s.short_p = !s.long_seen; // R19
          next_s.long_p = s.long_seen; // R19
        end
      end else begin
        next_s.deb_cnt = s.deb_cnt + 32'd1;
      end
    end else begin
      next_s.deb_cnt = '0;
    end
    if (!s.level) begin
      next_s.hold_cnt = '0;
      if (KEY_RAW == s.level) next_s.long_seen = 1'b0;
    end else if (s.hold_cnt >= 32'(LONG_CYC - 1)) begin
      next_s.long_seen = 1'b1; // R3
    end else begin
      next_s.hold_cnt = s.hold_cnt + 32'd1;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) s <= '0;
    else s <= next_s;
  end

  assign SHORT_P = s.short_p;
  assign LONG_P  = s.long_p;
  assign LEVEL   = s.level;
endmodule : pks_key

// ### verification/pks_panel_checker.sv
// checker for pks_panel: indicators, status code, alarm clear, mode
// assumes it is bound onto pks_panel and sees only its ports
`timescale 1ns/1ps
module pks_panel_checker (
  // clock and reset
  input wire logic               SYS_CLK,
  input wire logic               RST,
  // drive status
  input wire pks_pkg::pks_axis_t AXIS_A,
  input wire pks_pkg::pks_axis_t AXIS_B,
  input wire logic               MAINS_READY,
  input wire logic               ALARM_RESET_IN,
  // operator and display outputs
  input wire pks_pkg::pks_mode_t MODE,
  input wire logic               AXIS_B_SEL,
  input wire logic [2:0]         DIGIT_SEL,
  input wire logic               DP_FLASH,
  input wire logic               EDIT_ACTIVE,
  input wire logic               ALARM_CLEAR,
  input wire logic [8:0]         INDICATORS,
  input wire pks_pkg::pks_code_t STATUS_CODE,
  input wire logic [7:0]         ALARM_NUM
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  // display is one cycle behind its inputs, so skip the edge after reset
  property p_run;
    !$past(RST) |-> INDICATORS[0] == $past(AXIS_A.servo_on) && INDICATORS[4] == $past(AXIS_B.servo_on);
  endproperty
  a_run: assert property (p_run) else $error("run segment wrong");
  property p_mains;
    !$past(RST) |-> INDICATORS[8] == $past(MAINS_READY);
  endproperty
  a_mains: assert property (p_mains) else $error("mains segment wrong");
  property p_trq;
    !$past(RST) |-> INDICATORS[2] == $past(32'(AXIS_A.torque) * 10 > 32'(AXIS_A.rated) * 11);
  endproperty
  a_trq: assert property (p_trq) else $error("torque segment wrong");
  property p_lim;
    !$past(RST) && $past(AXIS_A.fwd_proh != AXIS_A.rev_proh) |-> INDICATORS[3] == $past(AXIS_A.fwd_proh);
  endproperty
  a_lim: assert property (p_lim) else $error("limit segment wrong");
  property p_alm;
    !$past(RST) && $past(AXIS_A.alarm) |-> STATUS_CODE == pks_pkg::CODE_A_ALM && ALARM_NUM == $past(AXIS_A.alarm_num);
  endproperty
  a_alm: assert property (p_alm) else $error("alarm code wrong");
  property p_ot;
    !$past(RST) && $past(!AXIS_A.alarm && !AXIS_B.alarm && (AXIS_A.fwd_proh || AXIS_A.rev_proh))
      |-> STATUS_CODE == pks_pkg::CODE_A_OT;
  endproperty
  a_ot: assert property (p_ot) else $error("overtravel code wrong");
  property p_off;
    !$past(RST) && $past({AXIS_A.servo_on, AXIS_A.alarm, AXIS_A.fwd_proh, AXIS_A.rev_proh,
      AXIS_B.servo_on, AXIS_B.alarm, AXIS_B.fwd_proh, AXIS_B.rev_proh} == 8'h00)
      |-> STATUS_CODE == pks_pkg::CODE_ALL_OFF;
  endproperty
  a_off: assert property (p_off) else $error("all off code wrong");
  property p_clr;
    $rose(ALARM_RESET_IN) |-> ##[1:3] ALARM_CLEAR;
  endproperty
  a_clr: assert property (p_clr) else $error("reset input did not clear");
  property p_pulse;
    ALARM_CLEAR |=> !ALARM_CLEAR;
  endproperty
  a_pulse: assert property (p_pulse) else $error("clear not a pulse");
  property p_mode;
    $changed(MODE) |-> MODE == pks_pkg::pks_mode_t'($past(MODE) + 2'h1);
  endproperty
  a_mode: assert property (p_mode) else $error("mode out of order");
  property p_axis;
    $changed(AXIS_B_SEL) |-> $stable(MODE);
  endproperty
  a_axis: assert property (p_axis) else $error("axis toggle moved mode");
  property p_dig;
    DP_FLASH |-> EDIT_ACTIVE && DIGIT_SEL <= 3'h4;
  endproperty
  a_dig: assert property (p_dig) else $error("digit marker wrong");

  c_clr: cover property (ALARM_CLEAR);
  c_axis: cover property ($changed(AXIS_B_SEL));
  c_alm: cover property (STATUS_CODE == pks_pkg::CODE_A_ALM);
  c_flash: cover property (DP_FLASH);
endmodule : pks_panel_checker

bind pks_panel pks_panel_checker u_chk (.SYS_CLK(SYS_CLK), .RST(RST), .AXIS_A(AXIS_A), .AXIS_B(AXIS_B),
  .MAINS_READY(MAINS_READY), .ALARM_RESET_IN(ALARM_RESET_IN), .MODE(MODE), .AXIS_B_SEL(AXIS_B_SEL),
  .DIGIT_SEL(DIGIT_SEL), .DP_FLASH(DP_FLASH), .EDIT_ACTIVE(EDIT_ACTIVE), .ALARM_CLEAR(ALARM_CLEAR),
  .INDICATORS(INDICATORS), .STATUS_CODE(STATUS_CODE), .ALARM_NUM(ALARM_NUM));

// ### verification/pks_operator.sv
// operator model: presses panel keys with contact bounce
// assumes hold times are counted in SYS_CLK cycles
`timescale 1ns/1ps
module pks_operator (
  // clock
  input wire logic  SYS_CLK,
  // keys, high while pressed
  output logic [4:0] KEYS
);
  initial KEYS = 5'h00;
  // a one-cycle bounce before the steady hold, as real contacts do
  task automatic press(input int k, input int hold);
    @(posedge SYS_CLK) KEYS[k] <= 1'b1;
    @(posedge SYS_CLK) KEYS[k] <= 1'b0;
    @(posedge SYS_CLK) KEYS[k] <= 1'b1;
    repeat (hold) @(posedge SYS_CLK);
    KEYS[k] <= 1'b0;
    repeat (12) @(posedge SYS_CLK);
  endtask : press
  // level hold, for jogging
  task automatic set_key(input int k, input logic v);
    @(posedge SYS_CLK) KEYS[k] <= v;
  endtask : set_key
endmodule : pks_operator

// ### verification/panel_keypad_status_display_tb_top.sv
// testbench for pks_panel: keys, registers, interrupt and display
// assumes short debounce, long press and blink counts for speed
`timescale 1ns/1ps
module panel_keypad_status_display_tb_top;
  logic               sys_clk, rst, hsel, hwrite, hreadyout, hresp, irq, mains, alm_in, pos_a;
  logic               axis_b_sel, dp_flash, edit_active, jog_fwd, jog_rev, alarm_clear, lim_q;
  logic [31:0]        haddr, hwdata, hrdata, rd;
  logic [1:0]         htrans;
  logic [4:0]         keys;
  logic [15:0]        dev_a;
  logic [2:0]         digit_sel;
  logic [19:0]        edit_value;
  logic [8:0]         ind;
  logic [7:0]         alm_num;
  pks_pkg::pks_axis_t ax_a, ax_b;
  pks_pkg::pks_mode_t mode;
  pks_pkg::pks_code_t code;
  int                 miscompares, tests_run, clr_seen, lim_tg, i;

  pks_panel #(.DEB_CYC(4), .LONG_CYC(50), .BLINK_CYC(8)) uut (.SYS_CLK(sys_clk), .RST(rst), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
    .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata), .KEYS(keys), .AXIS_A(ax_a), .AXIS_B(ax_b),
    .POS_MODE_A(pos_a), .POS_DEV_A(dev_a), .MAINS_READY(mains), .ALARM_RESET_IN(alm_in), .MODE(mode),
    .AXIS_B_SEL(axis_b_sel), .DIGIT_SEL(digit_sel), .DP_FLASH(dp_flash), .EDIT_ACTIVE(edit_active),
    .EDIT_VALUE(edit_value), .JOG_FWD(jog_fwd), .JOG_REV(jog_rev), .ALARM_CLEAR(alarm_clear),
    .INDICATORS(ind), .STATUS_CODE(code), .ALARM_NUM(alm_num), .IRQ(irq));
  pks_operator op (.SYS_CLK(sys_clk), .KEYS(keys));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // clear pulses and limit flashing are counted as they happen
  always @(posedge sys_clk) begin
    if (alarm_clear === 1'b1) clr_seen++;
    if (ind[3] !== lim_q) lim_tg++;
    lim_q <= ind[3];
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one single transfer; the bus answer is awaited, never assumed
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask : rd_chk
  task automatic disp(input logic [8:0] ei, input pks_pkg::pks_code_t ec);
    repeat (3) @(posedge sys_clk);
    chk({23'h0, ind}, {23'h0, ei});
    chk({29'h0, code}, {29'h0, ec});
  endtask : disp
  task automatic report_and_stop;
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1; hsel = 1'b0; hwrite = 1'b0; htrans = 2'h0; haddr = 32'h0; hwdata = 32'h0;
    mains = 1'b0; alm_in = 1'b0; pos_a = 1'b0; dev_a = 16'hffff; lim_q = 1'b0;
    ax_a = '{servo_on: 1'b0, alarm: 1'b0, alarm_num: 8'h00, fwd_proh: 1'b0, rev_proh: 1'b0,
             torque: 16'h0000, rated: 16'h0064, spd_err: 16'hffff};
    ax_b = ax_a;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd_chk(pks_pkg::OFS_SPD_THR, 32'h0000000a);
    rd_chk(pks_pkg::OFS_POS_THR, 32'h0000000a);
    rd_chk(pks_pkg::OFS_ROT_THR, 32'h00000014);
    rd_chk(8'h40, 32'h0);
    disp(9'h000, pks_pkg::CODE_ALL_OFF);
    // four short presses walk every mode and wrap back
    for (i = 1; i <= 4; i++) begin
      op.press(pks_pkg::KEY_FUNC, 30);
      chk({30'h0, mode}, 32'(i % 4));
    end
    chk({31'h0, irq}, 32'h0);
    ahb(1'b1, pks_pkg::OFS_IRQ_MASK, 32'h1);
    @(posedge sys_clk) chk({31'h0, irq}, 32'h1);
    rd_chk(pks_pkg::OFS_IRQ_STAT, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    op.press(pks_pkg::KEY_FUNC, 60);
    chk({31'h0, axis_b_sel}, 32'h1);
    chk({30'h0, mode}, 32'h0);
    op.press(pks_pkg::KEY_SET, 5);
    chk(32'(clr_seen), 32'h1);
    alm_in <= 1'b1;
    op.press(pks_pkg::KEY_SHIFT, 5);
    alm_in <= 1'b0;
    chk(32'(clr_seen), 32'h2);
    op.press(pks_pkg::KEY_FUNC, 30);
    op.press(pks_pkg::KEY_FUNC, 30);
    op.press(pks_pkg::KEY_SET, 5);
    chk({31'h0, edit_active}, 32'h1);
    chk({29'h0, digit_sel}, 32'h0);
    op.press(pks_pkg::KEY_UP, 5);
    chk({12'h0, edit_value}, 32'h00001);
    op.press(pks_pkg::KEY_SHIFT, 5);
    chk({29'h0, digit_sel}, 32'h1);
    op.press(pks_pkg::KEY_DOWN, 5);
    chk({12'h0, edit_value}, 32'h00091);
    op.press(pks_pkg::KEY_SET, 5);
    // jog needs the auxiliary mode and the enable bit
    ahb(1'b1, pks_pkg::OFS_CTRL, 32'h1);
    for (i = 0; i < 3; i++) op.press(pks_pkg::KEY_FUNC, 30);
    op.set_key(pks_pkg::KEY_UP, 1'b1);
    repeat (10) @(posedge sys_clk);
    chk({31'h0, jog_fwd}, 32'h1);
    op.set_key(pks_pkg::KEY_UP, 1'b0);
    op.set_key(pks_pkg::KEY_DOWN, 1'b1);
    repeat (10) @(posedge sys_clk);
    chk({30'h0, jog_rev, jog_fwd}, 32'h2);
    op.set_key(pks_pkg::KEY_DOWN, 1'b0);
    // display cases, thresholds probed on both sides
    mains <= 1'b1; ax_a.servo_on <= 1'b1;
    disp(9'h101, pks_pkg::CODE_A_ON);
    ax_a.servo_on <= 1'b0; ax_b.servo_on <= 1'b1; ax_a.spd_err <= 16'd9;
    disp(9'h112, pks_pkg::CODE_B_ON);
    ahb(1'b1, pks_pkg::OFS_SPD_THR, 32'h9);
    disp(9'h110, pks_pkg::CODE_B_ON);
    pos_a <= 1'b1; dev_a <= 16'd9;
    disp(9'h112, pks_pkg::CODE_B_ON);
    dev_a <= 16'd10; ax_b.spd_err <= 16'd19;
    disp(9'h150, pks_pkg::CODE_B_ON);
    ax_b.spd_err <= 16'd20; ax_a.torque <= 16'd110; ax_b.torque <= 16'd111;
    disp(9'h130, pks_pkg::CODE_B_ON);
    ax_a.torque <= 16'd111; ax_a.fwd_proh <= 1'b1;
    disp(9'h13c, pks_pkg::CODE_A_OT);
    ax_a.fwd_proh <= 1'b0; ax_a.rev_proh <= 1'b1;
    disp(9'h134, pks_pkg::CODE_A_OT);
    ax_a.fwd_proh <= 1'b1; i = lim_tg;
    repeat (30) @(posedge sys_clk);
    chk(32'(lim_tg - i > 2), 32'h1);
    ax_a.alarm <= 1'b1; ax_a.alarm_num <= 8'h2a;
    repeat (3) @(posedge sys_clk);
    chk({29'h0, code}, {29'h0, pks_pkg::CODE_A_ALM});
    chk({24'h0, alm_num}, 32'h2a);
    // a second reset in mid-run puts the panel back to status mode
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    chk({29'h0, axis_b_sel, mode}, 32'h0);
    report_and_stop();
  end
endmodule : panel_keypad_status_display_tb_top
